// >>> bus_pkg.sv
package bus_pkg;
   // address and data bus widths
   localparam int ADDR_W = 20;
   localparam int DATA_W = 8;
   // reset vector of the processor
   localparam logic [19:0] RESET_VECTOR = 20'hF_FFF0;
   // code segment bases used by firmware
   localparam logic [15:0] UPPER_CS_BASE = 16'hF800;
   localparam logic [15:0] LOWER_CS_BASE = 16'h0000;
   // memory map ranges
   localparam logic [19:0] UPPER_ROM_LO = 20'hF_F800;
   localparam logic [19:0] UPPER_ROM_HI = 20'hF_FFFF;
   localparam logic [19:0] LOWER_ROM_LO = 20'h0_0000;
   localparam logic [19:0] LOWER_ROM_HI = 20'h0_07FF;
   localparam logic [19:0] RAM_LO       = 20'h0_0800;
   localparam logic [19:0] RAM_HI       = 20'h0_08FF;
   // io block bases, 128 addresses each
   localparam logic [15:0] IO_ROM1_BASE = 16'h0000;
   localparam logic [15:0] IO_ROM2_BASE = 16'h0080;
   localparam logic [15:0] IO_RAM_BASE  = 16'h0100;
   // sizes
   localparam int ROM_BYTES = 2048;
   localparam int RAM_BYTES = 256;
   localparam int PROGRAM_KB = 4;
   // clock figures
   localparam int CLK_MHZ = 200;
   localparam int CPU_CLK_MHZ = 5;
   localparam int CPU_DIV = CLK_MHZ / CPU_CLK_MHZ;
   localparam int CPU_HALF = CPU_DIV / 2;
   // reset values
   localparam logic [7:0] PORT_RST = 8'h00;
   localparam logic [7:0] DDR_RST  = 8'h00;
   localparam logic [7:0] CMD_RST  = 8'h00;
   // command register field: port a, b, c output enables
   localparam int CMD_PA_OUT = 0;
   localparam int CMD_PB_OUT = 1;
   localparam int CMD_PC_OUT = 2;

   typedef enum logic [1:0] {SEL_NONE, SEL_ROM1, SEL_ROM2, SEL_RAM} dev_sel_t;

   // one bus cycle request as seen on the buffered bus
   typedef struct packed {
      logic       ale;      // address latch enable
      logic       read_n;   // read strobe, active low
      logic       write_n;  // write strobe, active low
      logic       io_m;     // high selects io ports
      logic [11:0] addr_hi; // upper address bits, held by cpu
   } bus_ctl_t;
endpackage

// >>> byte_mem.sv
`timescale 1ns/100ps
// synchronous byte memory with registered read data
module byte_mem #(
   parameter int DEPTH = 256,
   parameter int AW    = 8,
   parameter bit ROM   = 0
) (
   input  wire logic          clk,      // system clock
   input  wire logic          we,       // write strobe
   input  wire logic [AW-1:0] addr,     // byte address
   input  wire logic [7:0]    wdata,    // write data
   output logic      [7:0]    rdata     // registered read data
);
   logic [7:0] mem [DEPTH];             // storage array

   ////////////////////////////////////////////////////////////////
   // write port (unused for program storage) and registered read
   always_ff @(posedge clk)
   begin
      if (we && !ROM)
      begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule

// >>> io_port.sv
`timescale 1ns/100ps
// one 8-bit port: output latch plus per-bit direction
module io_port (
   input  wire logic       clk,          // system clock
   input  wire logic       arst_n,       // async reset, active low
   input  wire logic       data_we,      // write port latch
   input  wire logic       dir_we,       // write direction register
   input  wire logic [7:0] wdata,        // write data
   input  wire logic [7:0] pin_in,       // pin levels
   output logic      [7:0] pin_out,      // latched output levels
   output logic      [7:0] pin_oe_n,     // low where the bit drives
   output logic      [7:0] rdata         // readback of the port
);
   import bus_pkg::*;
   logic [7:0] latch;                    // last written value
   logic [7:0] dir;                      // 1 = output bit
   wire  [7:0] mixed = (dir & latch) | (~dir & pin_in); // readback mix

   ////////////////////////////////////////////////////////////////
   // latch holds until written again, direction set by firmware
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         latch    <= PORT_RST;
         dir      <= DDR_RST;
         pin_out  <= PORT_RST;
         pin_oe_n <= 8'hFF;
         rdata    <= PORT_RST;
      end
      else
      begin
         if (data_we)
         begin
            latch <= wdata;              // [RULE12]
         end
         if (dir_we)
         begin
            dir <= wdata;                // [RULE13]
         end
         pin_out  <= latch;              // [RULE12]
         pin_oe_n <= ~dir;               // [RULE13]
         rdata    <= mixed;
      end
   end
endmodule

// >>> cpu_memory_io_bus.sv
`timescale 1ns/100ps
// Functional notes
// RULE1: fetch starts at reset vector FFFF0
// RULE2: upper rom answers FF800 to FFFFF
// RULE3: lower rom answers 00000 to 007FF
// RULE4: two 2 KB roms, 4 KB program
// RULE5: firmware keeps data/stack segments zero
// RULE6: address byte first, then data byte
// RULE7: latch holds low address byte
// RULE8: transceiver direction follows read strobe
// RULE9: transceiver outputs always enabled
// RULE10: ram array when selected, io low
// RULE11: io ports when selected, io high
// RULE12: output port bits hold written value
// RULE13: per-bit direction register per rom
// RULE14: firmware sets rom port directions
// RULE15: firmware sets ram ports to outputs
// RULE16: processor clock is 5 MHz
// RULE17: latch loads on falling ale
// RULE18: unmapped addresses select no device
module cpu_memory_io_bus (
   input  wire logic                    clk,            // 200 MHz system clock
   input  wire logic                    arst_n,         // async reset, active low
   input  wire bus_pkg::bus_ctl_t       ctl,            // cpu bus control
   input  wire logic [7:0]              cpu_local_addr_data_bus, // cpu side bus
   input  wire logic [7:0]              buffered_in,    // buffered bus level
   output logic      [7:0]              buffered_addr_data_bus, // buffered drive
   output logic                         buffered_oe_n,  // low: drives buffer, device data on reads, cpu bus otherwise
   output logic      [7:0]              cpu_bus_out,    // drive toward cpu
   output logic                         cpu_bus_oe_n,   // low: drive toward cpu
   output logic                         xcvr_dir_to_cpu,// transceiver direction
   output logic                         xcvr_oe_n,      // transceiver enable
   output logic      [7:0]              low_addr,       // latched low address
   output bus_pkg::dev_sel_t            dev_sel,        // selected device
   output logic                         cpu_clk,        // 5 MHz processor clock
   output logic      [19:0]             fetch_addr,     // captured address, reset vector after reset
   input  wire logic [7:0]              rom1_pa_in,     // rom1 port a pins
   input  wire logic [7:0]              rom1_pb_in,     // rom1 port b pins
   input  wire logic [7:0]              rom2_pa_in,     // rom2 port a pins
   input  wire logic [7:0]              rom2_pb_in,     // rom2 port b pins
   input  wire logic [7:0]              ram_pa_in,      // ram port a pins
   input  wire logic [7:0]              ram_pb_in,      // ram port b pins
   input  wire logic [7:0]              ram_pc_in,      // ram port c pins
   output logic      [55:0]             port_out,       // all seven port levels
   output logic      [55:0]             port_oe_n       // low where bits drive
);
   import bus_pkg::*;

   ////////////////////////////////////////////////////////////////
   // processor clock divider
   logic [5:0] div_cnt;                                 // divider count
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         div_cnt <= 6'h00;
         cpu_clk <= 1'b0;
      end
      else if (div_cnt == 6'(CPU_HALF - 1))
      begin
         div_cnt <= 6'h00;
         cpu_clk <= ~cpu_clk;                           // [RULE16]
      end
      else
      begin
         div_cnt <= div_cnt + 6'h01;
      end
   end

   ////////////////////////////////////////////////////////////////
   // address phase: falling ale captures the transient address
   logic ale_d;                                         // ale delayed
   logic [19:0] addr;                                   // full captured address
   logic        io_cyc;                                 // cycle is io
   wire  ale_fall = ale_d && !ctl.ale;                  // trailing edge of ale
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ale_d    <= 1'b0;
         low_addr <= 8'h00;
         addr     <= RESET_VECTOR;                      // [RULE1]
         io_cyc   <= 1'b0;
      end
      else
      begin
         ale_d <= ctl.ale;
         if (ale_fall)
         begin
            low_addr <= buffered_in;                    // [RULE7] [RULE17] [RULE6]
            addr     <= {ctl.addr_hi, buffered_in};     // [RULE6]
            io_cyc   <= ctl.io_m;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // decode of the memory map and io blocks
   function automatic dev_sel_t decode(input logic [19:0] a, input logic io);
      if (io)
      begin
         if (a[15:7] == IO_ROM1_BASE[15:7])
            decode = SEL_ROM1;
         else if (a[15:7] == IO_ROM2_BASE[15:7])
            decode = SEL_ROM2;
         else if (a[15:7] == IO_RAM_BASE[15:7])
            decode = SEL_RAM;
         else
            decode = SEL_NONE;
      end
      else if (a >= UPPER_ROM_LO && a <= UPPER_ROM_HI)
         decode = SEL_ROM1;                             // [RULE2]
      else if (a <= LOWER_ROM_HI)
         decode = SEL_ROM2;                             // [RULE3]
      else if (a >= RAM_LO && a <= RAM_HI)
         decode = SEL_RAM;
      else
         decode = SEL_NONE;                             // [RULE18]
   endfunction

   wire dev_sel_t sel     = decode(addr, io_cyc);       // current selection
   wire logic     rd_act  = !ctl.read_n;                // read in progress
   wire logic     wr_act  = !ctl.write_n;               // write in progress
   logic          wr_d;                                 // write delayed
   logic          wr_d2;                                // write delayed twice
   // second strobe cycle: the registered buffered copy now holds the data byte,
   // not the address byte still seen in the first strobe cycle
   wire logic     wr_fall = wr_act && wr_d && !wr_d2;   // one write per cycle [RULE6]
   wire logic     ram_mem = (sel == SEL_RAM) && !io_cyc; // [RULE10]
   wire logic     any_io  = (sel != SEL_NONE) && io_cyc; // [RULE11]

   ////////////////////////////////////////////////////////////////
   // program and data storage
   logic [7:0] rom_up_q, rom_lo_q, ram_q;               // memory read data
   byte_mem #(.DEPTH(ROM_BYTES), .AW(11), .ROM(1)) u_rom_up (
      .clk   (clk),
      .we    (1'b0),
      .addr  (addr[10:0]),
      .wdata (8'h00),
      .rdata (rom_up_q)
   );                                                   // [RULE4]
   byte_mem #(.DEPTH(ROM_BYTES), .AW(11), .ROM(1)) u_rom_lo (
      .clk   (clk),
      .we    (1'b0),
      .addr  (addr[10:0]),
      .wdata (8'h00),
      .rdata (rom_lo_q)
   );                                                   // [RULE4]
   byte_mem #(.DEPTH(RAM_BYTES), .AW(8), .ROM(0)) u_ram (
      .clk   (clk),
      .we    (ram_mem && wr_fall),                      // [RULE10]
      .addr  (addr[7:0]),
      .wdata (buffered_in),
      .rdata (ram_q)
   );

   ////////////////////////////////////////////////////////////////
   // io ports: rom1 a/b, rom2 a/b, ram a/b/c
   wire logic io_wr = any_io && wr_fall;                // io write pulse
   wire logic [2:0] reg_a = addr[2:0];                  // port register index
   logic [7:0] cmd;                                     // ram command register
   logic [7:0] p_rd [7];                                // port readbacks
   wire  [7:0] pins [7] = '{rom1_pa_in, rom1_pb_in, rom2_pa_in, rom2_pb_in,
                             ram_pa_in, ram_pb_in, ram_pc_in};
   genvar g;
   generate
      for (g = 0; g < 7; g++)
      begin : g_port
         localparam int CHIP = (g < 2) ? 0 : ((g < 4) ? 1 : 2);
         localparam int IDX  = (g < 4) ? (g % 2) : (g - 4);
         wire dev_sel_t mine = dev_sel_t'(2'(CHIP + 1));
         wire logic     hit  = io_wr && (sel == mine);
         wire logic     dwe  = hit && ((CHIP == 2) ? (reg_a == 3'(IDX + 1))
                                                   : (reg_a == 3'(IDX)));
         wire logic     rwe  = (CHIP == 2) ? (io_wr && sel == SEL_RAM && reg_a == 3'h0)
                                           : (hit && reg_a == 3'(IDX + 2));
         wire logic [7:0] dwd = (CHIP == 2) ? {8{buffered_in[IDX]}} : buffered_in;
         io_port u_port (
            .clk      (clk),
            .arst_n   (arst_n),
            .data_we  (dwe),                            // [RULE11]
            .dir_we   (rwe),                            // [RULE13]
            .wdata    ((CHIP == 2 && rwe) ? dwd : buffered_in),
            .pin_in   (pins[g]),
            .pin_out  (port_out[g*8 +: 8]),
            .pin_oe_n (port_oe_n[g*8 +: 8]),
            .rdata    (p_rd[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////
   // ram command register readback copy
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cmd   <= CMD_RST;
         wr_d  <= 1'b0;
         wr_d2 <= 1'b0;
      end
      else
      begin
         wr_d  <= wr_act;
         wr_d2 <= wr_d && wr_act;
         if (io_wr && sel == SEL_RAM && reg_a == 3'h0)
         begin
            cmd <= buffered_in;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // read data mux toward the cpu
   wire logic [7:0] io_q =
      (sel == SEL_ROM1) ? p_rd[addr[0]] :
      (sel == SEL_ROM2) ? p_rd[2 + addr[0]] :
      (reg_a == 3'h0)   ? cmd :
      (reg_a >= 3'h1 && reg_a <= 3'h3) ? p_rd[4 + (reg_a - 3'h1)] : 8'h00;
   wire logic [7:0] mem_q =
      (sel == SEL_ROM1) ? rom_up_q :
      (sel == SEL_ROM2) ? rom_lo_q : ram_q;
   wire logic [7:0] rd_q = any_io ? io_q : mem_q;       // [RULE11] [RULE10]
   wire logic drive_cpu  = rd_act && (sel != SEL_NONE); // [RULE18]

   ////////////////////////////////////////////////////////////////
   // transceiver: direction from read strobe, outputs always on
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         xcvr_dir_to_cpu        <= 1'b0;
         xcvr_oe_n              <= 1'b0;
         buffered_addr_data_bus <= 8'h00;
         buffered_oe_n          <= 1'b1;
         cpu_bus_out            <= 8'h00;
         cpu_bus_oe_n           <= 1'b1;
         dev_sel                <= SEL_NONE;
         fetch_addr             <= RESET_VECTOR;        // [RULE1]
      end
      else
      begin
         xcvr_dir_to_cpu        <= rd_act;              // [RULE8]
         xcvr_oe_n              <= 1'b0;                // [RULE9]
         buffered_addr_data_bus <= rd_act ? rd_q : cpu_local_addr_data_bus; // [RULE8]
         buffered_oe_n          <= !(drive_cpu || !rd_act); // [RULE9] [RULE18]
         cpu_bus_out            <= rd_q;
         cpu_bus_oe_n           <= !drive_cpu;          // [RULE8]
         dev_sel                <= sel;
         fetch_addr             <= addr;
      end
   end
endmodule

// >>> cpu_memory_io_bus_monitor.sv
`timescale 1ns/100ps
// assertions on the bus block, seen from its top ports
module cpu_memory_io_bus_monitor
   import bus_pkg::*;
(
   input wire logic        clk,             // clock
   input wire logic        arst_n,          // reset
   input wire bus_ctl_t    ctl,             // cpu control
   input wire logic [7:0]  buffered_in,     // bus level
   input wire logic        buffered_oe_n,   // bus drive
   input wire logic        xcvr_dir_to_cpu, // direction
   input wire logic        xcvr_oe_n,       // enable
   input wire logic [7:0]  low_addr,        // address latch
   input wire dev_sel_t    dev_sel,         // selection
   input wire logic        cpu_clk,         // cpu clock
   input wire logic [19:0] fetch_addr       // captured address
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic [5:0] cnt;  // samples the cpu clock level has stood
   logic       lvl;  // cpu clock at the last sample
   logic       seen; // a cpu clock edge has passed
   // measure each cpu clock half period
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
         {cnt, lvl, seen} <= '0;
      else if (cpu_clk != lvl)
         {cnt, lvl, seen} <= {6'd1, cpu_clk, 1'b1};
      else
         cnt <= cnt + 6'd1;
   property p_vec; $rose(arst_n) |-> fetch_addr == RESET_VECTOR; endproperty
   a_vec: assert property (p_vec) else $error("bad reset fetch address");
   property p_xen; xcvr_oe_n == 1'b0; endproperty
   a_xen: assert property (p_xen) else $error("transceiver disabled");
   property p_dir; xcvr_dir_to_cpu == !$past(ctl.read_n); endproperty
   a_dir: assert property (p_dir) else $error("direction not following read");
   property p_boe; ctl.read_n |=> !buffered_oe_n; endproperty
   a_boe: assert property (p_boe) else $error("buffered bus left undriven");
   property p_lat; $fell(ctl.ale) |=> low_addr == $past(buffered_in); endproperty
   a_lat: assert property (p_lat) else $error("low byte not latched");
   property p_hold; !$fell(ctl.ale) |=> $stable(low_addr); endproperty
   a_hold: assert property (p_hold) else $error("latch changed");
   property p_up; $fell(ctl.ale) && !ctl.io_m && ctl.addr_hi >= 12'hFF8
      |-> ##[1:4] dev_sel == SEL_ROM1; endproperty
   a_up: assert property (p_up) else $error("upper rom not selected");
   property p_lo; $fell(ctl.ale) && !ctl.io_m && ctl.addr_hi <= 12'h007
      |-> ##[1:4] dev_sel == SEL_ROM2; endproperty
   a_lo: assert property (p_lo) else $error("lower rom not selected");
   property p_none; $fell(ctl.ale) && !ctl.io_m && ctl.addr_hi inside {[12'h009:12'hFF7]}
      |-> ##[1:4] dev_sel == SEL_NONE; endproperty
   a_none: assert property (p_none) else $error("unmapped address selected");
   property p_half; seen && cpu_clk != lvl |-> cnt == 6'(CPU_HALF); endproperty
   a_half: assert property (p_half) else $error("cpu clock half period wrong");
   property p_run; cnt <= 6'(CPU_HALF); endproperty
   a_run: assert property (p_run) else $error("cpu clock stopped");
endmodule
bind cpu_memory_io_bus cpu_memory_io_bus_monitor u_mon (.clk, .arst_n, .ctl, .buffered_in,
   .buffered_oe_n, .xcvr_dir_to_cpu, .xcvr_oe_n, .low_addr, .dev_sel, .cpu_clk, .fetch_addr);

// >>> cpu_bus_model.sv
`timescale 1ns/100ps
// processor side of the bus: one transfer per go pulse
module cpu_bus_model
   import bus_pkg::*;
(
   input wire logic        clk,    // clock
   input wire logic        arst_n, // reset
   input wire logic        go,     // start a transfer
   input wire logic        rd,     // read when high
   input wire logic        io,     // io space when high
   input wire logic [19:0] addr,   // address
   input wire logic [7:0]  wdata,  // write data
   output bus_ctl_t        ctl,    // bus control
   output logic [7:0]      bus,    // cpu side bus
   output logic            busy,   // transfer running
   output logic            smp     // last strobe cycle
);
   logic [3:0] ph;  // phase: 1-2 ale, 3-4 hold, 5-8 strobe, 9-10 recover
   logic       act; // strobe phase
   // step through the phases of one transfer
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
         ph <= '0;
      else if (go)
         ph <= 4'd1;
      else if (busy)
         ph <= (ph == 4'd10) ? 4'd0 : ph + 4'd1;
   assign busy = ph != 4'd0;
   assign act  = ph >= 4'd5 && ph <= 4'd8;
   assign smp  = ph == 4'd8;
   assign ctl  = '{ale: busy && ph <= 4'd2, read_n: !(act && rd), write_n: !(act && !rd),
                   io_m: io, addr_hi: addr[19:8]};
   // address byte first, then data; a released bus shows the inverse
   assign bus = (busy && ph <= 4'd4) ? addr[7:0] : (act && !rd) ? wdata : ~addr[7:0];
endmodule

// >>> cpu_memory_io_bus_tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
// bench: model drives transfers, notes are compared at each strobe end
module cpu_memory_io_bus_tb;
   import bus_pkg::*;
   typedef struct packed {
      logic [55:0] oe; // port enables
      logic [55:0] po; // port levels
      logic [19:0] fa; // captured address
      dev_sel_t    ds; // selection
      logic [7:0]  la; // latched low byte
      logic [7:0]  rd; // read data
   } obs_t;
   localparam obs_t MS = obs_t'({112'h0, 20'hF_FFFF, 2'b11, 8'hFF, 8'h00});
   localparam obs_t MR = obs_t'({112'h0, 20'hF_FFFF, 2'b11, 8'hFF, 8'hFF});
   logic        clk, arst_n, go, rd, io, boe_n, coe_n, dirc, xoe_n, cclk, busy, smp;
   logic [19:0] adr, fa;
   logic [7:0]  wd, cbus, bin, bout, cout, la;
   logic [55:0] pin, po, poe;
   bus_ctl_t    ctl;
   dev_sel_t    ds;
   obs_t        obs, m, v;
   obs_t        qm[$], qv[$];
   int          error_cnt = 0, n_checks = 0, tick = 0;
   logic [7:0]  lfsr = 8'h10;
   logic [7:0]  d [6];
   logic [19:0] ra [4];
   logic [7:0]  rv [4];
   logic [19:0] amap [8] = '{20'hF_F800, 20'hF_FFFF, 20'h0_0000, 20'h0_07FF,
                             20'h0_0800, 20'h0_08FF, 20'h0_0900, 20'hF_F7FF};
   dev_sel_t    smap [8] = '{SEL_ROM1, SEL_ROM1, SEL_ROM2, SEL_ROM2,
                             SEL_RAM, SEL_RAM, SEL_NONE, SEL_NONE};
   // released buffered bus shows the inverse of the last drive
   assign bin = boe_n ? ~bout : bout;
   assign obs = {poe, po, fa, ds, la, cout};
   cpu_bus_model u_cpu (.clk(clk), .arst_n(arst_n), .go(go), .rd(rd), .io(io), .addr(adr),
      .wdata(wd), .ctl(ctl), .bus(cbus), .busy(busy), .smp(smp));
   cpu_memory_io_bus dut (.clk(clk), .arst_n(arst_n), .ctl(ctl),
      .cpu_local_addr_data_bus(cbus), .buffered_in(bin), .buffered_addr_data_bus(bout),
      .buffered_oe_n(boe_n), .cpu_bus_out(cout), .cpu_bus_oe_n(coe_n),
      .xcvr_dir_to_cpu(dirc), .xcvr_oe_n(xoe_n), .low_addr(la), .dev_sel(ds),
      .cpu_clk(cclk), .fetch_addr(fa), .rom1_pa_in(pin[7:0]), .rom1_pb_in(pin[15:8]),
      .rom2_pa_in(pin[23:16]), .rom2_pb_in(pin[31:24]), .ram_pa_in(pin[39:32]),
      .ram_pb_in(pin[47:40]), .ram_pc_in(pin[55:48]), .port_out(po), .port_oe_n(poe));
   // random byte source
   function automatic logic [7:0] nx();
      lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      return lfsr;
   endfunction
   // port enable and level field of one port
   function automatic obs_t pk(int b, logic [7:0] e, logic [7:0] p);
      obs_t x;
      x = '0;
      x.oe[b+:8] = e;
      x.po[b+:8] = p;
      return x;
   endfunction
   // selection, address and read data fields
   function automatic obs_t sel(dev_sel_t s, logic [19:0] a, logic [7:0] r);
      return obs_t'({112'h0, a, s, a[7:0], r});
   endfunction
   // one transfer, with its masked expectation noted first
   task automatic cyc(logic r, logic i, logic [19:0] a, logic [7:0] dd, obs_t mm, obs_t vv);
      qm.push_back(mm);
      qv.push_back(vv & mm);
      @(posedge clk);
      go <= 1'b1;
      {rd, io, adr, wd} <= {r, i, a, dd};
      @(posedge clk);
      go <= 1'b0;
      @(negedge clk);
      while (busy) @(negedge clk);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // compare the oldest note at the end of each strobe
   always @(posedge clk)
      if (smp)
      begin
         m = qm.pop_front();
         v = qv.pop_front();
         `CHK(obs & m, v)
      end
   // cut a hang short
   always @(posedge clk)
   begin
      tick++;
      if (tick == 3000)
      begin
         error_cnt++;
         conclude();
      end
   end
   initial
   begin
      {go, rd, io, adr, wd} = '0;
      pin = {nx(), nx(), nx(), nx(), nx(), nx(), nx()};
      arst_n = 1'b0;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      @(negedge clk);
      `CHK(fa, RESET_VECTOR)
      `CHK(xoe_n, 1'b0)
      `CHK(poe, {56{1'b1}})
      $display("test reset done");
      for (int k = 0; k < 8; k++)
         cyc(1'b1, 1'b0, amap[k], 8'h00, MS, sel(smap[k], amap[k], 8'h00));
      $display("test memory map done"); // edges of each range and unmapped ones
      for (int k = 0; k < 4; k++)
      begin
         ra[k] = {12'h008, 6'(nx()), 2'(k)};
         rv[k] = nx();
         cyc(1'b0, 1'b0, ra[k], rv[k], MS, sel(SEL_RAM, ra[k], 8'h00));
      end
      for (int k = 0; k < 4; k++)
         cyc(1'b1, 1'b0, ra[k], 8'h00, MR, sel(SEL_RAM, ra[k], rv[k]));
      $display("test ram done");
      for (int k = 0; k < 6; k++)
         d[k] = nx();
      cyc(1'b0, 1'b1, 20'h0_0002, 8'hFF, pk(0, 8'hFF, 8'h00), '0);
      cyc(1'b0, 1'b1, 20'h0_0003, 8'hFF, pk(8, 8'hFF, 8'h00), '0);
      cyc(1'b0, 1'b1, 20'h0_0000, d[0], pk(0, 8'hFF, 8'hFF), pk(0, 8'h00, d[0]));
      cyc(1'b0, 1'b1, 20'h0_0001, d[1], pk(8, 8'hFF, 8'hFF), pk(8, 8'h00, d[1]));
      cyc(1'b0, 1'b1, 20'h0_0083, 8'h07, pk(24, 8'hFF, 8'h00), pk(24, 8'hF8, 8'h00));
      cyc(1'b0, 1'b1, 20'h0_0081, d[2], pk(24, 8'hFF, 8'h07), pk(24, 8'hF8, d[2]));
      cyc(1'b0, 1'b1, 20'h0_0100, 8'h07, pk(32, 8'hFF, 0) | pk(40, 8'hFF, 0)
          | pk(48, 8'hFF, 0), '0);
      cyc(1'b0, 1'b1, 20'h0_0101, d[3], pk(32, 8'hFF, 8'hFF), pk(32, 8'h00, d[3]));
      cyc(1'b0, 1'b1, 20'h0_0102, d[4], pk(0, 8'hFF, 8'hFF) | pk(40, 8'h00, 8'hFF),
          pk(0, 8'h00, d[0]) | pk(40, 8'h00, d[4]));
      $display("test io ports done");
      conclude();
   end
endmodule
